// *** hdl/vcgf_params.svh ***
// Register indices, reset values and timing figures of the video control block
`ifndef VCGF_PARAMS_SVH
`define VCGF_PARAMS_SVH

// Register indices, byte address is four times the index
`define VCGF_IDX_GREEN_SYNC   6'h04
`define VCGF_IDX_INPUT_CFG    6'h05
`define VCGF_IDX_GAIN0        6'h06
`define VCGF_IDX_GAIN1        6'h07
`define VCGF_IDX_GAIN2        6'h08
`define VCGF_IDX_OFFS0        6'h09
`define VCGF_IDX_OFFS1        6'h0A
`define VCGF_IDX_OFFS2        6'h0B
`define VCGF_IDX_CLAMP_SRC    6'h13
`define VCGF_IDX_START_HI     6'h14
`define VCGF_IDX_START_LO     6'h15
`define VCGF_IDX_CLAMP_WIDTH  6'h16
`define VCGF_IDX_BLACK_CTRL   6'h17
`define VCGF_IDX_OUT_FORMAT   6'h18
`define VCGF_IDX_CLAMP_SET    6'h23
`define VCGF_IDX_STATUS       6'h30
`define VCGF_IDX_APPLIED0     6'h31

// Field positions
`define VCGF_CFG_DC_COUPLE    1
`define VCGF_CFG_YUV          2
`define VCGF_CFG_COAST_CLAMP  5
`define VCGF_FMT_DECIMATE     4
`define VCGF_BLK_DISABLE      0

// Reset values
`define VCGF_RST_GREEN_SYNC   8'h00
`define VCGF_RST_INPUT_CFG    8'h00
`define VCGF_RST_GAIN         8'h55
`define VCGF_RST_OFFS         8'h80
`define VCGF_RST_CLAMP_SRC    8'h00
`define VCGF_RST_START_HI     8'h00
`define VCGF_RST_START_LO     8'h08
`define VCGF_RST_CLAMP_WIDTH  8'h10
`define VCGF_RST_BLACK_CTRL   8'h00
`define VCGF_RST_OUT_FORMAT   8'h00
`define VCGF_RST_CLAMP_SET    8'h08

// Codes
`define VCGF_MID_SCALE        10'h080
`define VCGF_UNITY_GAIN       8'h55

// Timing
`define VCGF_CLK_HZ           10000000
`define VCGF_GAIN_TMO_MS      100
`define VCGF_GAIN_TMO_CYC     ((`VCGF_GAIN_TMO_MS * `VCGF_CLK_HZ) / 1000)
`define VCGF_ACT_WIN_CYC      65536

`endif

// *** hdl/vcgf_pkg.sv ***
// Types shared by the video control block
package vcgf_pkg;

   typedef struct packed {
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
   } vcgf_pix_t;

   typedef enum logic [1:0] {
      CLAMP_IDLE = 2'b00,
      CLAMP_WAIT = 2'b01,
      CLAMP_ON   = 2'b10
   } vcgf_clamp_state_t;

endpackage

// *** hdl/vcgf_top.sv ***
// Gain, clamp timing, input format and output format control of a triple video digitizer
//
// Contract
// - Three independent 8-bit gain registers, consecutive
// - Gain is 0.5 plus code over 170
// - Offset 0x80 gives black code, chroma mid-scale
// - Separate offsets per red, green, blue
// - Config bit 2 selects YUV processing
// - YUV chroma black level at 0x80
// - No colour conversion, fixed channel mapping
// - Format bit 4 decimates to 4:2:2
// - Config bit 1 selects DC coupling
// - AC coupling: clamp once per line
// - Bit 5 zero suppresses clamp while coasting
// - Clamp starts at programmed pixel count
// - Clamp lasts width pixels then stops
// - Start may exceed active video length
// - Green sync threshold settings from register
// - Report activity of three sync sources
// - Gain applied on clamp pulse
// - Without clamp pulse, gain applied by 100ms
// - Black control bit 0 disables compensation
`include "vcgf_params.svh"

module vcgf_top #(
   parameter int GAIN_TMO_CYC = `VCGF_GAIN_TMO_CYC,
   parameter int ACT_WIN_CYC  = `VCGF_ACT_WIN_CYC
) (
   // Clock, reset, enable
   input  wire logic                CLK_SYS_IN,
   input  wire logic                ARST_N_IN,
   input  wire logic                CE_IN,
   // APB slave
   input  wire logic                PSEL_IN,
   input  wire logic                PENABLE_IN,
   input  wire logic                PWRITE_IN,
   input  wire logic [7:0]          PADDR_IN,
   input  wire logic [31:0]         PWDATA_IN,
   output logic      [31:0]         PRDATA_OUT,
   output logic                     PREADY_OUT,
   output logic                     PSLVERR_OUT,
   // Sync and timing inputs
   input  wire logic                HSYNC_IN,
   input  wire logic                VSYNC_IN,
   input  wire logic                GREEN_SYNC_IN,
   input  wire logic                COAST_IN,
   input  wire logic                EXT_CLAMP_IN,
   // Pixel stream in
   input  wire logic                PIX_EN_IN,
   input  wire logic                ACTIVE_IN,
   input  wire vcgf_pkg::vcgf_pix_t PIX_IN,
   // Pixel stream out
   output vcgf_pkg::vcgf_pix_t      PIX_OUT,
   output logic                     PIX_VALID_OUT,
   // Analog control
   output logic      [23:0]         GAIN_OUT,
   output logic      [23:0]         OFFSET_DAC_OUT,
   output logic                     CLAMP_OUT,
   output logic                     DC_COUPLE_OUT,
   output logic      [7:0]          GREEN_SYNC_CTRL_OUT,
   output logic      [2:0]          CLAMP_IMPED_OUT
);

   ////////////////////////////////////////////////////////////////////////////////
   // Register file
   logic [7:0]  green_sync_threshold_q;
   logic [7:0]  input_configuration_q;
   logic [7:0]  gain_setting_value_q [3];
   logic [7:0]  offset_q [3];
   logic [7:0]  clamp_source_select_q;
   logic [7:0]  clamp_start_pixel_high_q;
   logic [7:0]  clamp_start_pixel_low_q;
   logic [7:0]  clamp_width_pixels_q;
   logic [7:0]  black_ctrl_q;
   logic [7:0]  output_format_q;
   logic [7:0]  clamp_settings_q;
   logic [2:0]  activity_q;
   logic [5:0]  idx;
   logic        wr_en;
   logic        rd_hit;
   logic [7:0]  rd_val;

   assign idx   = PADDR_IN[7:2];
   assign wr_en = PSEL_IN & PENABLE_IN & PWRITE_IN & PREADY_OUT;

   always_comb
   begin
      rd_hit = 1'b1;
      rd_val = 8'h00;
      unique case (idx)
         `VCGF_IDX_GREEN_SYNC:  rd_val = green_sync_threshold_q;
         `VCGF_IDX_INPUT_CFG:   rd_val = input_configuration_q;
         `VCGF_IDX_GAIN0:       rd_val = gain_setting_value_q[0];
         `VCGF_IDX_GAIN1:       rd_val = gain_setting_value_q[1];
         `VCGF_IDX_GAIN2:       rd_val = gain_setting_value_q[2];
         `VCGF_IDX_OFFS0:       rd_val = offset_q[0];
         `VCGF_IDX_OFFS1:       rd_val = offset_q[1];
         `VCGF_IDX_OFFS2:       rd_val = offset_q[2];
         `VCGF_IDX_CLAMP_SRC:   rd_val = clamp_source_select_q;
         `VCGF_IDX_START_HI:    rd_val = clamp_start_pixel_high_q;
         `VCGF_IDX_START_LO:    rd_val = clamp_start_pixel_low_q;
         `VCGF_IDX_CLAMP_WIDTH: rd_val = clamp_width_pixels_q;
         `VCGF_IDX_BLACK_CTRL:  rd_val = black_ctrl_q;
         `VCGF_IDX_OUT_FORMAT:  rd_val = output_format_q;
         `VCGF_IDX_CLAMP_SET:   rd_val = clamp_settings_q;
         `VCGF_IDX_STATUS:      rd_val = {4'h0, CLAMP_OUT, activity_q};
         `VCGF_IDX_APPLIED0:    rd_val = GAIN_OUT[7:0];
         `VCGF_IDX_APPLIED0 + 6'h01: rd_val = GAIN_OUT[15:8];
         `VCGF_IDX_APPLIED0 + 6'h02: rd_val = GAIN_OUT[23:16];
         default:               rd_hit = 1'b0;
      endcase
   end

   // Three-cycle access: pready rises one edge into the access phase
   always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         PREADY_OUT  <= 1'b0;
         PRDATA_OUT  <= 32'h0000_0000;
         PSLVERR_OUT <= 1'b0;
      end
      else if (CE_IN)
      begin
         if (PSEL_IN && PENABLE_IN && !PREADY_OUT)
         begin
            PREADY_OUT  <= 1'b1;
            PRDATA_OUT  <= PWRITE_IN ? 32'h0000_0000 : {24'h00_0000, rd_val};
            PSLVERR_OUT <= ~rd_hit;
         end
         else
         begin
            PREADY_OUT  <= 1'b0;
            PRDATA_OUT  <= 32'h0000_0000;
            PSLVERR_OUT <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         green_sync_threshold_q   <= `VCGF_RST_GREEN_SYNC;
         input_configuration_q    <= `VCGF_RST_INPUT_CFG;
         clamp_source_select_q    <= `VCGF_RST_CLAMP_SRC;
         clamp_start_pixel_high_q <= `VCGF_RST_START_HI;
         clamp_start_pixel_low_q  <= `VCGF_RST_START_LO;
         clamp_width_pixels_q     <= `VCGF_RST_CLAMP_WIDTH;
         black_ctrl_q             <= `VCGF_RST_BLACK_CTRL;
         output_format_q          <= `VCGF_RST_OUT_FORMAT;
         clamp_settings_q         <= `VCGF_RST_CLAMP_SET;
      end
      else if (CE_IN && wr_en)
      begin
         unique case (idx)
            `VCGF_IDX_GREEN_SYNC:  green_sync_threshold_q   <= PWDATA_IN[7:0];
            `VCGF_IDX_INPUT_CFG:   input_configuration_q    <= PWDATA_IN[7:0];
            `VCGF_IDX_CLAMP_SRC:   clamp_source_select_q    <= PWDATA_IN[7:0];
            `VCGF_IDX_START_HI:    clamp_start_pixel_high_q <= PWDATA_IN[7:0];
            `VCGF_IDX_START_LO:    clamp_start_pixel_low_q  <= PWDATA_IN[7:0];
            `VCGF_IDX_CLAMP_WIDTH: clamp_width_pixels_q     <= PWDATA_IN[7:0];
            `VCGF_IDX_BLACK_CTRL:  black_ctrl_q             <= PWDATA_IN[7:0];
            `VCGF_IDX_OUT_FORMAT:  output_format_q          <= PWDATA_IN[7:0];
            `VCGF_IDX_CLAMP_SET:   clamp_settings_q         <= PWDATA_IN[7:0];
            default:               ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sync edges and line clamp timing
   logic                         hsync_q;
   logic                         ext_clamp_q;
   logic                         hs_trail;
   logic                         ext_pulse;
   logic                         ext_clamp_sel;
   logic                         coast_allowed;
   logic [15:0]                  start_cnt;
   vcgf_pkg::vcgf_clamp_state_t  clamp_state_q;
   logic [15:0]                  pix_cnt_q;
   logic [7:0]                   width_cnt_q;
   logic                         line_coast_q;
   logic                         clamp_pulse_q;
   logic                         load_gain;
   logic [31:0]                  tmo_cnt_q;

   assign hs_trail      = hsync_q & ~HSYNC_IN;
   assign ext_pulse     = EXT_CLAMP_IN & ~ext_clamp_q;
   assign ext_clamp_sel = |clamp_source_select_q[5:4];
   assign coast_allowed = input_configuration_q[`VCGF_CFG_COAST_CLAMP];
   assign start_cnt     = {clamp_start_pixel_high_q, clamp_start_pixel_low_q};

   always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         hsync_q     <= 1'b0;
         ext_clamp_q <= 1'b0;
      end
      else if (CE_IN)
      begin
         hsync_q     <= HSYNC_IN;
         ext_clamp_q <= EXT_CLAMP_IN;
      end
   end

   // Full 16-bit start lets the window land past active video, on the front porch
   always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         clamp_state_q <= vcgf_pkg::CLAMP_IDLE;
         pix_cnt_q     <= 16'h0000;
         width_cnt_q   <= 8'h00;
         clamp_pulse_q <= 1'b0;
      end
      else if (CE_IN)
      begin
         clamp_pulse_q <= 1'b0;
         if (hs_trail)
         begin
            clamp_state_q <= vcgf_pkg::CLAMP_WAIT;
            pix_cnt_q     <= 16'h0000;
         end
         else if (PIX_EN_IN)
         begin
            unique case (clamp_state_q)
               vcgf_pkg::CLAMP_IDLE: ;
               vcgf_pkg::CLAMP_WAIT:
               begin
                  if (pix_cnt_q == start_cnt)
                  begin
                     clamp_pulse_q <= 1'b1;
                     width_cnt_q   <= 8'h00;
                     clamp_state_q <= (clamp_width_pixels_q == 8'h00) ?
                                      vcgf_pkg::CLAMP_IDLE : vcgf_pkg::CLAMP_ON;
                  end
                  else
                  begin
                     pix_cnt_q <= pix_cnt_q + 16'h0001;
                  end
               end
               vcgf_pkg::CLAMP_ON:
               begin
                  width_cnt_q <= width_cnt_q + 8'h01;
                  if (width_cnt_q == clamp_width_pixels_q - 8'h01)
                  begin
                     clamp_state_q <= vcgf_pkg::CLAMP_IDLE;
                  end
               end
               default: clamp_state_q <= vcgf_pkg::CLAMP_IDLE;
            endcase
         end
      end
   end

   // Coasting marks the line from its first coast cycle until the next trailing edge
   always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         line_coast_q <= 1'b0;
      end
      else if (CE_IN)
      begin
         if (hs_trail)
         begin
            line_coast_q <= COAST_IN;
         end
         else if (COAST_IN)
         begin
            line_coast_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         CLAMP_OUT <= 1'b0;
      end
      else if (CE_IN)
      begin
         CLAMP_OUT <= !input_configuration_q[`VCGF_CFG_DC_COUPLE]
                      && !ext_clamp_sel
                      && !(line_coast_q && !coast_allowed)
                      && ((clamp_state_q == vcgf_pkg::CLAMP_ON
                           && !(PIX_EN_IN && width_cnt_q == clamp_width_pixels_q - 8'h01))
                          || (clamp_state_q == vcgf_pkg::CLAMP_WAIT && PIX_EN_IN
                              && pix_cnt_q == start_cnt
                              && clamp_width_pixels_q != 8'h00));
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Gain transfer to the amplifiers
   assign load_gain = (ext_clamp_sel ? ext_pulse : clamp_pulse_q)
                      || (tmo_cnt_q >= 32'(GAIN_TMO_CYC - 1));

   always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         tmo_cnt_q <= 32'h0000_0000;
      end
      else if (CE_IN)
      begin
         tmo_cnt_q <= load_gain ? 32'h0000_0000 : tmo_cnt_q + 32'h0000_0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Per-channel gain, offset and black level; index 0 red, 1 green, 2 blue
   logic [7:0] ch_in  [3];
   logic [7:0] ch_adj [3];
   logic       yuv;
   logic       blk_on;

   assign yuv      = input_configuration_q[`VCGF_CFG_YUV];
   assign blk_on   = !black_ctrl_q[`VCGF_BLK_DISABLE];
   assign ch_in[0] = PIX_IN.red;
   assign ch_in[1] = PIX_IN.green;
   assign ch_in[2] = PIX_IN.blue;

   genvar ch;
   generate
      for (ch = 0; ch < 3; ch++)
      begin : g_chan
         logic [9:0] sum;
         logic [9:0] mid;

         // Incoming codes are black-nulled; chroma black sits at mid-scale in YUV
         assign mid = (yuv && ch != 1) ? `VCGF_MID_SCALE : 10'h000;
         assign sum = {2'b00, ch_in[ch]} + {2'b00, offset_q[ch]} + mid
                      - `VCGF_MID_SCALE;
         // Saturate instead of wrapping so brightness shifts never fold over
         assign ch_adj[ch] = !blk_on ? ch_in[ch] :
                             sum[9] ? 8'h00 : (sum[8] ? 8'hFF : sum[7:0]);

         always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
         begin
            if (!ARST_N_IN)
            begin
               gain_setting_value_q[ch] <= `VCGF_RST_GAIN;
               offset_q[ch]             <= `VCGF_RST_OFFS;
            end
            else if (CE_IN && wr_en)
            begin
               if (idx == `VCGF_IDX_GAIN0 + 6'(ch))
               begin
                  gain_setting_value_q[ch] <= PWDATA_IN[7:0];
               end
               if (idx == `VCGF_IDX_OFFS0 + 6'(ch))
               begin
                  offset_q[ch] <= PWDATA_IN[7:0];
               end
            end
         end

         // Code drives the amplifier as 0.5 + code/170
         always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
         begin
            if (!ARST_N_IN)
            begin
               GAIN_OUT[8*ch +: 8]       <= `VCGF_UNITY_GAIN;
               OFFSET_DAC_OUT[8*ch +: 8] <= `VCGF_RST_OFFS;
            end
            else if (CE_IN)
            begin
               if (load_gain)
               begin
                  GAIN_OUT[8*ch +: 8] <= gain_setting_value_q[ch];
               end
               // Manual DAC follows offset only with compensation off
               OFFSET_DAC_OUT[8*ch +: 8] <= blk_on ? `VCGF_RST_OFFS : offset_q[ch];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Output format
   logic active_q;
   logic odd_q;

   always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         active_q <= 1'b0;
         odd_q    <= 1'b0;
      end
      else if (CE_IN && PIX_EN_IN)
      begin
         active_q <= ACTIVE_IN;
         if (ACTIVE_IN && !active_q)
         begin
            odd_q <= 1'b1;
         end
         else
         begin
            odd_q <= ~odd_q;
         end
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         PIX_OUT       <= '0;
         PIX_VALID_OUT <= 1'b0;
      end
      else if (CE_IN)
      begin
         PIX_VALID_OUT <= PIX_EN_IN;
         if (PIX_EN_IN)
         begin
            PIX_OUT.green <= ch_adj[1];
            if (output_format_q[`VCGF_FMT_DECIMATE])
            begin
               PIX_OUT.blue <= 8'h00;
               PIX_OUT.red  <= (ACTIVE_IN && !active_q) || !odd_q ?
                               ch_adj[2] : ch_adj[0];
            end
            else
            begin
               PIX_OUT.blue <= ch_adj[2];
               PIX_OUT.red  <= ch_adj[0];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sync source activity: edge seen within the last window
   logic [2:0]  src_in;
   logic [2:0]  src_q;
   logic [2:0]  seen_q;
   logic [31:0] win_cnt_q;
   logic        win_end;

   assign src_in  = {GREEN_SYNC_IN, VSYNC_IN, HSYNC_IN};
   assign win_end = win_cnt_q >= 32'(ACT_WIN_CYC - 1);

   always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         win_cnt_q <= 32'h0000_0000;
      end
      else if (CE_IN)
      begin
         win_cnt_q <= win_end ? 32'h0000_0000 : win_cnt_q + 32'h0000_0001;
      end
   end

   genvar s;
   generate
      for (s = 0; s < 3; s++)
      begin : g_act
         always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
         begin
            if (!ARST_N_IN)
            begin
               src_q[s]      <= 1'b0;
               seen_q[s]     <= 1'b0;
               activity_q[s] <= 1'b0;
            end
            else if (CE_IN)
            begin
               src_q[s] <= src_in[s];
               if (win_end)
               begin
                  activity_q[s] <= seen_q[s] | (src_q[s] ^ src_in[s]);
                  seen_q[s]     <= 1'b0;
               end
               else if (src_q[s] ^ src_in[s])
               begin
                  seen_q[s] <= 1'b1;
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Analog control outputs
   always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         DC_COUPLE_OUT       <= 1'b0;
         GREEN_SYNC_CTRL_OUT <= `VCGF_RST_GREEN_SYNC;
         CLAMP_IMPED_OUT     <= 3'h0;
      end
      else if (CE_IN)
      begin
         DC_COUPLE_OUT       <= input_configuration_q[`VCGF_CFG_DC_COUPLE];
         GREEN_SYNC_CTRL_OUT <= green_sync_threshold_q;
         CLAMP_IMPED_OUT     <= clamp_settings_q[6:4];
      end
   end

endmodule // vcgf_top

// *** bench/vcgf_monitor.sv ***
// Port-level assertions for the video control block
module vcgf_monitor (
   // Clock, reset, enable
   input wire logic        CLK_SYS_IN,
   input wire logic        ARST_N_IN,
   input wire logic        CE_IN,
   // Register bus
   input wire logic        PSEL_IN,
   input wire logic        PENABLE_IN,
   input wire logic        PREADY_OUT,
   input wire logic        PSLVERR_OUT,
   input wire logic [31:0] PRDATA_OUT,
   // Line timing
   input wire logic        HSYNC_IN,
   input wire logic        CLAMP_OUT,
   input wire logic        DC_COUPLE_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   logic seen_q;
   default clocking @(posedge CLK_SYS_IN); endclocking
   default disable iff (!ARST_N_IN);
   ////////////////////////////////////////
   // Clamp seen since the last trailing edge
   always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
      if (!ARST_N_IN) seen_q <= 1'b0;
      else if ($fell(HSYNC_IN)) seen_q <= 1'b0;
      else if (CLAMP_OUT) seen_q <= 1'b1;
   ////////////////////////////////////////
   a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
      else $error("pready held past one cycle");
   a_ready_wait: assert property (PSEL_IN && PENABLE_IN && CE_IN && !PREADY_OUT |=> PREADY_OUT)
      else $error("no answer one cycle after access");
   a_rdata_idle: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h00000000)
      else $error("read data outside answer cycle");
   a_rdata_byte: assert property (PRDATA_OUT[31:8] == 24'h000000)
      else $error("read data upper bits set");
   a_err_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
      else $error("error without ready");
   a_dc_no_clamp: assert property ($past(DC_COUPLE_OUT) && DC_COUPLE_OUT |-> !CLAMP_OUT)
      else $error("clamp while dc coupled");
   a_clamp_once: assert property ($rose(CLAMP_OUT) |-> !seen_q)
      else $error("second clamp in one line");
   a_clamp_late: assert property ($fell(HSYNC_IN) && !CLAMP_OUT |=> !CLAMP_OUT)
      else $error("clamp before start count");
endmodule // vcgf_monitor

// *** bench/vcgf_video_src.sv ***
// Line-timed video source with sync, active window and a colour bar
module vcgf_video_src (
   input  wire logic           clk_in,
   input  wire logic           arst_n_in,
   output logic                hsync_out,
   output logic                active_out,
   output vcgf_pkg::vcgf_pix_t pix_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [5:0] pos_q;
   always_ff @(posedge clk_in or negedge arst_n_in)
      if (!arst_n_in) pos_q <= 6'h00;
      else pos_q <= pos_q + 6'h01;
   // 64-pixel line; 31 active pixels so chroma parity would drift per line
   assign hsync_out  = pos_q < 6'h04;
   assign active_out = pos_q > 6'h13 && pos_q < 6'h33;
   // Blanking shows a moving pattern, never the last colour
   assign pix_out = active_out ? {8'hA0, 8'h50, 8'h30} : {3{2'b00, pos_q}};
endmodule // vcgf_video_src

// *** bench/video_clamp_gain_format_ctrl_tb_top.sv ***
// Self-checking bench of the video control block
`include "vcgf_params.svh"
module video_clamp_gain_format_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [5:0] idx; logic [7:0] val; logic [23:0] pix;} vcgf_row_t;
   logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, coast = 0, err, hs, act;
   logic [7:0] paddr = 0, gsc;
   logic [31:0] pwdata = 0, rd, prdata;
   logic pready, pslverr, clamp, dcc, pv, ce = 1, ext = 0;
   logic [2:0] imp;
   logic [23:0] gain, offs;
   vcgf_pkg::vcgf_pix_t pix_in, pix_out;
   int num_errors = 0, samples_checked = 0, d, w, d0;
   vcgf_row_t rows [9] = '{
      '{`VCGF_IDX_OFFS0, 8'h90, 24'hB05030}, '{`VCGF_IDX_OFFS1, 8'h70, 24'hB04030},
      '{`VCGF_IDX_OFFS0, 8'h80, 24'hA04030}, '{`VCGF_IDX_GAIN1, 8'h66, 24'hA04030},
      '{`VCGF_IDX_INPUT_CFG, 8'h04, 24'hFF40B0}, '{`VCGF_IDX_BLACK_CTRL, 8'h01, 24'hA05030},
      '{`VCGF_IDX_INPUT_CFG, 8'h00, 24'hA05030}, '{`VCGF_IDX_GREEN_SYNC, 8'h0B, 24'hA05030},
      '{`VCGF_IDX_CLAMP_SET, 8'h58, 24'hA05030}};
   always #50 clk = ~clk;
   vcgf_top #(.GAIN_TMO_CYC(200), .ACT_WIN_CYC(64)) dut (
      .CLK_SYS_IN(clk), .ARST_N_IN(rst_n), .CE_IN(ce), .PSEL_IN(psel),
      .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
      .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
      .HSYNC_IN(hs), .VSYNC_IN(act), .GREEN_SYNC_IN(1'b0), .COAST_IN(coast),
      .EXT_CLAMP_IN(ext), .PIX_EN_IN(1'b1), .ACTIVE_IN(act), .PIX_IN(pix_in),
      .PIX_OUT(pix_out), .PIX_VALID_OUT(pv), .GAIN_OUT(gain), .OFFSET_DAC_OUT(offs),
      .CLAMP_OUT(clamp), .DC_COUPLE_OUT(dcc), .GREEN_SYNC_CTRL_OUT(gsc),
      .CLAMP_IMPED_OUT(imp));
   vcgf_video_src src (.clk_in(clk), .arst_n_in(rst_n), .hsync_out(hs),
      .active_out(act), .pix_out(pix_in));
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr_en, input logic [5:0] idx, input logic [7:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= wr_en;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] idx, input logic [7:0] v);
      apb(1'b1, idx, v);
   endtask
   task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      chk(rd, {24'h000000, exp});
   endtask
   // Clamp delay from trailing edge and clamp length over one line
   task automatic scan;
      d = 0;
      w = 0;
      wait (hs === 1'b1);
      wait (hs === 1'b0);
      repeat (58)
      begin
         @(posedge clk);
         if (clamp === 1'b1) w++;
         else if (w == 0) d++;
      end
   endtask
   task automatic summarize;
      $display("checks %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////
   initial
   begin
      repeat (30000) @(posedge clk);
      num_errors++;
      summarize();
   end
   initial
   begin
      repeat (5) @(posedge clk);
      chk(gain, {3{`VCGF_UNITY_GAIN}});
      chk(offs, 24'h808080);
      rst_n <= 1'b1;
      rdc(`VCGF_IDX_GAIN2, `VCGF_RST_GAIN);
      rdc(`VCGF_IDX_INPUT_CFG, 8'h00);
      rdc(6'h3F, 8'h00);
      chk(err, 1'b1);
      foreach (rows[i])
      begin
         wr(rows[i].idx, rows[i].val);
         rdc(rows[i].idx, rows[i].val);
         wait (act === 1'b0);
         wait (act === 1'b1);
         repeat (4) @(posedge clk);
         #1 chk(pix_out, rows[i].pix);
      end
      chk(offs, 24'h807080);
      chk(gsc, 8'h0B);
      chk(imp, 3'h5);
      rdc(`VCGF_IDX_APPLIED0 + 6'h01, 8'h66);
      scan();
      d0 = d;
      chk(w, `VCGF_RST_CLAMP_WIDTH);
      wr(`VCGF_IDX_START_LO, 8'h30);
      wr(`VCGF_IDX_CLAMP_WIDTH, 8'h06);
      scan();
      chk(d - d0, 40);
      chk(w, 6);
      coast <= 1'b1;
      scan();
      chk(w, 0);
      wr(`VCGF_IDX_INPUT_CFG, 8'h20);
      scan();
      chk(w, 6);
      coast <= 1'b0;
      wait (clamp === 1'b1);
      wait (clamp === 1'b0);
      wr(`VCGF_IDX_GAIN2, 8'h22);
      chk(gain[23:16], `VCGF_RST_GAIN);
      scan();
      chk(gain[23:16], 8'h22);
      wr(`VCGF_IDX_INPUT_CFG, 8'h02);
      scan();
      chk(w, 0);
      chk(dcc, 1'b1);
      rdc(`VCGF_IDX_STATUS, 8'h03);
      // External clamp chosen but never driven: only the fallback timer loads
      wr(`VCGF_IDX_CLAMP_SRC, 8'h10);
      wr(`VCGF_IDX_INPUT_CFG, 8'h00);
      wr(`VCGF_IDX_GAIN0, 8'h11);
      scan();
      chk(w, 0);
      d = 0;
      while (gain[7:0] !== 8'h11 && d < 300)
      begin
         @(posedge clk);
         d++;
      end
      chk(gain[7:0], 8'h11);
      // Timer was just reloaded, so only the external edge can load now
      wr(`VCGF_IDX_GAIN1, 8'h44);
      chk(gain[15:8], 8'h66);
      ext <= 1'b1;
      @(posedge clk);
      ext <= 1'b0;
      @(posedge clk);
      chk(gain[15:8], 8'h44);
      wr(`VCGF_IDX_OUT_FORMAT, 8'h10);
      repeat (2)
      begin
         wait (act === 1'b0);
         wait (act === 1'b1);
         @(posedge clk);
         #1 chk(pix_out, 24'h305000);
         @(posedge clk);
         #1 chk(pix_out, 24'hA05000);
      end
      // Enable low mid-line: the alternating red output must freeze
      @(posedge clk);
      ce <= 1'b0;
      @(posedge clk);
      d0 = pix_out;
      repeat (4) @(posedge clk);
      chk(pix_out, d0);
      chk(pv, 1'b1);
      summarize();
   end
endmodule // video_clamp_gain_format_ctrl_tb_top
bind vcgf_top vcgf_monitor u_mon (.CLK_SYS_IN(CLK_SYS_IN), .ARST_N_IN(ARST_N_IN),
   .CE_IN(CE_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PREADY_OUT(PREADY_OUT),
   .PSLVERR_OUT(PSLVERR_OUT), .PRDATA_OUT(PRDATA_OUT), .HSYNC_IN(HSYNC_IN),
   .CLAMP_OUT(CLAMP_OUT), .DC_COUPLE_OUT(DC_COUPLE_OUT));
